// ==== rtl/rdv_defs.svh ====
`ifndef RDV_DEFS_SVH
`define RDV_DEFS_SVH
// Register offsets
`define RDV_REG_CTRL 8'h00
`define RDV_REG_CTRL2 8'h01
`define RDV_REG_VAL0 8'h02
`define RDV_REG_VAL1 8'h03
`define RDV_REG_VAL2 8'h04
`define RDV_REG_VAL3 8'h05
`define RDV_REG_STAT 8'h06
`define RDV_REG_RST 8'h00
// CTRL bits
`define RDV_B_THR_LO 0
`define RDV_B_FULLWAVE 1
`define RDV_B_BOTH_EDGES 2
`define RDV_B_RING_POL 3
`define RDV_B_INT_POL 4
`define RDV_B_PWR_DOWN 5
`define RDV_B_ONHOOK_MON 6
`define RDV_B_OFFHOOK 7
// CTRL2, VAL0 and STAT bits
`define RDV_B_THR_HI 0
`define RDV_B_IRQ_MASK 7
`define RDV_B_VAL_EN 7
`define RDV_B_POS 0
`define RDV_B_NEG 1
`define RDV_B_RDT 2
`define RDV_B_IRQ 7
// Thresholds, 10 mV per LSB of sense difference
`define RDV_THR_15V 17'sh005DC
`define RDV_THR_21V 17'sh00834
`define RDV_THR_45V 17'sh01194
// Ring codes in the PCM stream
`define RDV_CODE_HIGH 16'h7FFF
`define RDV_CODE_LOW 16'h8000
`define RDV_CODE_MID 16'h04CC
// Timing
`define RDV_CLK_KHZ 10000
`define RDV_ONESHOT_MS 5000
`define RDV_TICK_DIV 2048
`define RDV_TMO_STEP 6'h02
`define RDV_RMX_STEP 6'h01
`define RDV_RCC_STEP 6'h20
`define RDV_RTO_STEP 6'h3F
`define RDV_DLY_STEP 6'h3F
`endif

// ==== rtl/rdv_pkg.sv ====
package rdv_pkg;
  typedef enum logic [3:0] {
    VIDLE = 4'h1,
    VCHECK = 4'h2,
    VDELAY = 4'h4,
    VRING = 4'h8
  } rdv_val_e;
  typedef logic [11:0] rdv_cnt_t;
endpackage

// ==== rtl/rdv_ring_detect.sv ====
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rdv_defs.svh"
module rdv_ring_detect #(
  parameter int ONESHOT_CYC = `RDV_ONESHOT_MS * `RDV_CLK_KHZ,
  parameter int TICK_DIV = `RDV_TICK_DIV,
  parameter logic [5:0] TMO_STEP = `RDV_TMO_STEP,
  parameter logic [5:0] RMX_STEP = `RDV_RMX_STEP,
  parameter logic [5:0] RCC_STEP = `RDV_RCC_STEP,
  parameter logic [5:0] RTO_STEP = `RDV_RTO_STEP,
  parameter logic [5:0] DLY_STEP = `RDV_DLY_STEP
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic signed [15:0] ringSenseInA,
  input wire logic signed [15:0] ringSenseInB,
  input wire logic pcmClk,
  input wire logic [15:0] pcmCodecSample,
  output logic [15:0] pcmTxSamples,
  output logic ringIndicatorPinOut,
  output logic ringIndicatorPinOe_n,
  output logic irqOutPin
);
  localparam int OSW = $clog2(ONESHOT_CYC + 1);
  localparam int TDW = $clog2(TICK_DIV + 1);

  if (ONESHOT_CYC < 1 || TICK_DIV < 1 || TMO_STEP == 6'h00 ||
      RMX_STEP == 6'h00 || RCC_STEP == 6'h00 ||
      RTO_STEP == 6'h00 || DLY_STEP == 6'h00)
  begin : g_bad_param
    $error("rdv_ring_detect: counts and steps must be nonzero");
  end

  function automatic rdv_pkg::rdv_cnt_t lim(
    input logic [5:0] field,
    input logic [5:0] step);
    return rdv_pkg::rdv_cnt_t'(field) * rdv_pkg::rdv_cnt_t'(step);
  endfunction

  function automatic rdv_pkg::rdv_cnt_t inc(
    input rdv_pkg::rdv_cnt_t v,
    input logic en);
    if (en && v != 12'hFFF)
    begin
      return v + 12'h001;
    end
    return v;
  endfunction

  logic [7:0] ctrlQ, ctrl2Q, val0Q, val1Q, val2Q, val3Q;
  logic posQ, negQ, rdtQ, irqFlagQ, indActQ;
  logic [1:0] lastPolQ;
  logic [OSW-1:0] osCntQ;
  logic pcmClkQ;
  logic [TDW-1:0] tickCntQ;
  logic tick;
  rdv_pkg::rdv_val_e valStateQ;
  rdv_pkg::rdv_cnt_t ivlQ, durQ;

  // Control fields
  logic thrLo, thrHi, fullWave, bothEdges, ringPolHi, intPolHi;
  logic linkPowerDown, onhookMon, offHook, irqMask, valEn;
  assign thrLo = ctrlQ[`RDV_B_THR_LO];
  assign fullWave = ctrlQ[`RDV_B_FULLWAVE];
  assign bothEdges = ctrlQ[`RDV_B_BOTH_EDGES];
  assign ringPolHi = ctrlQ[`RDV_B_RING_POL];
  assign intPolHi = ctrlQ[`RDV_B_INT_POL];
  assign linkPowerDown = ctrlQ[`RDV_B_PWR_DOWN];
  assign onhookMon = ctrlQ[`RDV_B_ONHOOK_MON];
  assign offHook = ctrlQ[`RDV_B_OFFHOOK];
  assign thrHi = ctrl2Q[`RDV_B_THR_HI];
  assign irqMask = ctrl2Q[`RDV_B_IRQ_MASK];
  assign valEn = val0Q[`RDV_B_VAL_EN];

  rdv_pkg::rdv_cnt_t limTmo, limRmx, limRcc, limRto, limDly;
  assign limTmo = lim(val0Q[5:0], TMO_STEP);
  assign limRmx = lim(val1Q[5:0], RMX_STEP);
  assign limRcc = lim({3'h0, val2Q[2:0]}, RCC_STEP);
  assign limRto = lim({2'h0, val2Q[6:3]}, RTO_STEP);
  assign limDly = lim({3'h0, val3Q[2:0]}, DLY_STEP);

  logic statWr, offHookEvt;
  assign statWr = regWr && regAddr == `RDV_REG_STAT;
  assign offHookEvt = regWr && regAddr == `RDV_REG_CTRL &&
                      regWrData[`RDV_B_OFFHOOK] && !offHook;

  // Register writes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlQ <= `RDV_REG_RST;
      ctrl2Q <= `RDV_REG_RST;
      val0Q <= `RDV_REG_RST;
      val1Q <= `RDV_REG_RST;
      val2Q <= `RDV_REG_RST;
      val3Q <= `RDV_REG_RST;
    end
    else if (regWr)
    begin
      case (regAddr)
        `RDV_REG_CTRL: ctrlQ <= regWrData;
        `RDV_REG_CTRL2: ctrl2Q <= regWrData;
        `RDV_REG_VAL0: val0Q <= regWrData;
        `RDV_REG_VAL1: val1Q <= regWrData;
        `RDV_REG_VAL2: val2Q <= regWrData;
        `RDV_REG_VAL3: val3Q <= regWrData;
        default: ;
      endcase
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData <= 8'h00;
    end
    else if (!regRd)
    begin
      regRdData <= 8'h00;
    end
    else
    begin
      case (regAddr)
        `RDV_REG_CTRL: regRdData <= ctrlQ;
        `RDV_REG_CTRL2: regRdData <= ctrl2Q & 8'h81;
        `RDV_REG_VAL0: regRdData <= val0Q & 8'hBF;
        `RDV_REG_VAL1: regRdData <= val1Q & 8'h3F;
        `RDV_REG_VAL2: regRdData <= val2Q & 8'h7F;
        `RDV_REG_VAL3: regRdData <= val3Q & 8'h07;
        `RDV_REG_STAT: regRdData <= {irqFlagQ, 4'h0, rdtQ, negQ, posQ};
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // Threshold compare
  logic signed [16:0] senseDiff, thr;
  logic aboveThr, belowThr;
  assign senseDiff = {ringSenseInA[15], ringSenseInA} -
                     {ringSenseInB[15], ringSenseInB};
  always_comb
  begin
    case ({thrHi, thrLo})
      2'b00: thr = `RDV_THR_15V;
      2'b01: thr = `RDV_THR_21V;
      default: thr = `RDV_THR_45V;
    endcase
  end
  assign aboveThr = senseDiff > thr;
  assign belowThr = senseDiff < -thr;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      posQ <= 1'b0;
      negQ <= 1'b0;
    end
    else
    begin
      posQ <= aboveThr;
      negQ <= belowThr;
    end
  end

  logic detRaw;
  assign detRaw = posQ || (fullWave && negQ);

  // Retriggerable one-shot
  logic osActive;
  assign osActive = osCntQ != '0;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osCntQ <= '0;
    end
    else if (offHookEvt || offHook)
    begin
      osCntQ <= '0;
    end
    else if (detRaw)
    begin
      osCntQ <= OSW'(ONESHOT_CYC);
    end
    else if (osActive)
    begin
      osCntQ <= osCntQ - OSW'(1);
    end
  end

  // Timebase from PCM clock rising edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcmClkQ <= 1'b0;
      tickCntQ <= '0;
    end
    else
    begin
      pcmClkQ <= pcmClk;
      if (pcmClk && !pcmClkQ)
      begin
        tickCntQ <= tick ? '0 : tickCntQ + TDW'(1);
      end
    end
  end
  assign tick = pcmClk && !pcmClkQ &&
                tickCntQ == TDW'(TICK_DIV - 1);

  // Alternating crossings
  logic posRise, negRise, crossEvt;
  assign posRise = aboveThr && !posQ;
  assign negRise = belowThr && !negQ;
  assign crossEvt = (posRise && !lastPolQ[0]) ||
                    (negRise && !lastPolQ[1]);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastPolQ <= 2'h0;
    end
    else if (posRise)
    begin
      lastPolQ <= 2'h1;
    end
    else if (negRise)
    begin
      lastPolQ <= 2'h2;
    end
  end

  // Validator
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valStateQ <= rdv_pkg::VIDLE;
      ivlQ <= '0;
      durQ <= '0;
    end
    else if (!valEn || offHook)
    begin
      valStateQ <= rdv_pkg::VIDLE;
      ivlQ <= '0;
      durQ <= '0;
    end
    else
    begin
      case (valStateQ)
        rdv_pkg::VIDLE:
        begin
          ivlQ <= '0;
          durQ <= '0;
          if (crossEvt)
          begin
            valStateQ <= rdv_pkg::VCHECK;
          end
        end
        rdv_pkg::VCHECK:
        begin
          if ((crossEvt && ivlQ < limRmx) || ivlQ > limTmo)
          begin
            valStateQ <= rdv_pkg::VIDLE;
          end
          else if (durQ >= limRcc)
          begin
            valStateQ <= rdv_pkg::VDELAY;
            ivlQ <= crossEvt ? '0 : inc(ivlQ, tick);
            durQ <= '0;
          end
          else
          begin
            ivlQ <= crossEvt ? '0 : inc(ivlQ, tick);
            durQ <= inc(durQ, tick);
          end
        end
        rdv_pkg::VDELAY:
        begin
          if (ivlQ >= limRto)
          begin
            valStateQ <= rdv_pkg::VIDLE;
          end
          else if (durQ >= limDly)
          begin
            valStateQ <= rdv_pkg::VRING;
          end
          else
          begin
            ivlQ <= crossEvt ? '0 : inc(ivlQ, tick);
            durQ <= inc(durQ, tick);
          end
        end
        rdv_pkg::VRING:
        begin
          if (ivlQ >= limRto)
          begin
            valStateQ <= rdv_pkg::VIDLE;
          end
          else
          begin
            ivlQ <= crossEvt ? '0 : inc(ivlQ, tick);
          end
        end
        default: valStateQ <= rdv_pkg::VIDLE;
      endcase
    end
  end

  logic envelope, rdtNow, irqSet;
  assign envelope = valStateQ == rdv_pkg::VRING;
  assign rdtNow = valEn ? envelope : osActive;
  assign irqSet = (rdtNow && !rdtQ) ||
                  (bothEdges && !rdtNow && rdtQ);

  // Detected flag and interrupt flag; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdtQ <= 1'b0;
      irqFlagQ <= 1'b0;
    end
    else
    begin
      rdtQ <= rdtNow;
      if (irqSet)
      begin
        irqFlagQ <= 1'b1;
      end
      else if (statWr && regWrData[`RDV_B_IRQ])
      begin
        irqFlagQ <= 1'b0;
      end
    end
  end
  assign irqOutPin = !((irqFlagQ && irqMask) ^ intPolHi);

  // Ring indicator pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indActQ <= 1'b0;
    end
    else if (valEn)
    begin
      indActQ <= fullWave ? osActive : envelope;
    end
    else
    begin
      indActQ <= detRaw;
    end
  end
  assign ringIndicatorPinOut = 1'b0;
  assign ringIndicatorPinOe_n = !(indActQ ^ ringPolHi);

  // PCM sample substitution
  logic subst;
  logic [15:0] ringCode;
  assign subst = !linkPowerDown && !offHook && !onhookMon;
  always_comb
  begin
    if (posQ)
    begin
      ringCode = `RDV_CODE_HIGH;
    end
    else if (fullWave && !negQ)
    begin
      ringCode = `RDV_CODE_MID;
    end
    else
    begin
      ringCode = `RDV_CODE_LOW;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcmTxSamples <= 16'h0000;
    end
    else
    begin
      pcmTxSamples <= subst ? ringCode : pcmCodecSample;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rdtRise;
    !rdtQ ##1 rdtQ;
  endsequence
  sequence s_rdtFall;
    bothEdges && rdtQ ##1 bothEdges && !rdtQ;
  endsequence
  sequence s_confirm;
    valStateQ == rdv_pkg::VCHECK && valEn && !offHook &&
    !crossEvt && ivlQ <= limTmo && durQ >= limRcc;
  endsequence

  property p_posFlag;
    aboveThr |=> posQ && !negQ;
  endproperty
  a_posFlag: assert property (p_posFlag)
    else $error("positive flag missed");
  property p_halfCode;
    subst && !fullWave && !posQ |=> pcmTxSamples == 16'h8000;
  endproperty
  a_halfCode: assert property (p_halfCode)
    else $error("half-wave idle code wrong");
  property p_fullCode;
    subst && fullWave && !posQ && !negQ |=> pcmTxSamples == 16'h04CC;
  endproperty
  a_fullCode: assert property (p_fullCode)
    else $error("full-wave idle code wrong");
  property p_passThru;
    !subst |=> pcmTxSamples == $past(pcmCodecSample);
  endproperty
  a_passThru: assert property (p_passThru)
    else $error("codec sample not passed");
  property p_oneShot;
    detRaw && !offHook && !offHookEvt && !valEn ##1 !offHook && !valEn
      |-> osActive ##1 rdtQ;
  endproperty
  a_oneShot: assert property (p_oneShot)
    else $error("one-shot not retriggered");
  property p_offHook;
    offHookEvt |=> !osActive ##1 !rdtQ || valEn;
  endproperty
  a_offHook: assert property (p_offHook)
    else $error("off-hook did not clear");
  property p_irqRise;
    s_rdtRise |-> irqFlagQ;
  endproperty
  a_irqRise: assert property (p_irqRise)
    else $error("no interrupt on rise");
  property p_irqFall;
    s_rdtFall |-> irqFlagQ;
  endproperty
  a_irqFall: assert property (p_irqFall)
    else $error("no interrupt on fall");
  property p_confirm;
    s_confirm |=> valStateQ == rdv_pkg::VDELAY ##1 !envelope;
  endproperty
  a_confirm: assert property (p_confirm)
    else $error("confirm step wrong");
  property p_endFirst;
    valStateQ == rdv_pkg::VDELAY && valEn && !offHook &&
    ivlQ >= limRto |=> !envelope ##1 !rdtQ;
  endproperty
  a_endFirst: assert property (p_endFirst)
    else $error("ring shown after timeout");
  property p_irqPin;
    irqFlagQ && irqMask |-> irqOutPin == intPolHi;
  endproperty
  a_irqPin: assert property (p_irqPin)
    else $error("interrupt pin level wrong");
  property p_indPin;
    !valEn && posQ ##1 !valEn |-> ringIndicatorPinOe_n == ringPolHi;
  endproperty
  a_indPin: assert property (p_indPin)
    else $error("indicator pin level wrong");
endmodule

// ==== sim/rdv_host_model.sv ====
`timescale 1ns/1ps
module rdv_host_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ringIndicatorPinOut,
  input wire logic ringIndicatorPinOe_n,
  output logic pcmClk,
  output logic [15:0] pcmCodecSample,
  output logic ringPin
);
  // Pull-up on the open-drain ring line
  assign ringPin = ringIndicatorPinOe_n ? 1'b1 : ringIndicatorPinOut;

  // Free-running PCM clock at half the system rate
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pcmClk <= 1'b0;
    else
      pcmClk <= ~pcmClk;
  end

  // Codec samples change every cycle
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pcmCodecSample <= 16'h0000;
    else
      pcmCodecSample <= pcmCodecSample + 16'h1357;
  end
endmodule

// ==== sim/test_ring_detect_validate.sv ====
`timescale 1ns/1ps
`include "rdv_defs.svh"
module test_ring_detect_validate;
  logic ref_clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic signed [15:0] ringSenseInA;
  logic signed [15:0] ringSenseInB;
  logic pcmClk;
  logic [15:0] pcmCodecSample;
  logic [15:0] pcmTxSamples;
  logic ringIndicatorPinOut;
  logic ringIndicatorPinOe_n;
  logic irqOutPin;
  logic ringPin;
  logic [15:0] prevCodec;
  logic [7:0] v;
  int badCount;
  int checkCount;
  int thr [4];

  rdv_ring_detect #(
    .ONESHOT_CYC(200),
    .TICK_DIV(2),
    .RCC_STEP(6'h01),
    .RTO_STEP(6'h01),
    .DLY_STEP(6'h01)
  ) u_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .ringSenseInA(ringSenseInA),
    .ringSenseInB(ringSenseInB),
    .pcmClk(pcmClk),
    .pcmCodecSample(pcmCodecSample),
    .pcmTxSamples(pcmTxSamples),
    .ringIndicatorPinOut(ringIndicatorPinOut),
    .ringIndicatorPinOe_n(ringIndicatorPinOe_n),
    .irqOutPin(irqOutPin)
  );

  rdv_host_model u_host (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ringIndicatorPinOut(ringIndicatorPinOut),
    .ringIndicatorPinOe_n(ringIndicatorPinOe_n),
    .pcmClk(pcmClk),
    .pcmCodecSample(pcmCodecSample),
    .ringPin(ringPin)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) prevCodec <= pcmCodecSample;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    v = regRdData;
  endtask

  task automatic sv(input int d);
    @(posedge ref_clk);
    ringSenseInA <= 16'(d + 100);
    ringSenseInB <= 16'sh0064;
  endtask

  task automatic pulse(input int d);
    sv(d);
    sv(0);
  endtask

  task automatic ring(input int hp, input int n);
    repeat (n)
    begin
      sv(1501);
      cyc(hp);
      sv(-1501);
      cyc(hp);
    end
  endtask

  // Level step: status bits, PCM code, ring line
  task automatic st(input int d, input logic [7:0] es,
                    input logic [15:0] ep, input logic pn);
    sv(d);
    cyc(3);
    rd(8'h06);
    check(16'(v & 8'h03), 16'(es));
    check(pcmTxSamples, ep);
    check(16'(ringPin), 16'(pn));
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    conclude();
  end

  initial
  begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    ringSenseInA = 16'sh0000;
    ringSenseInB = 16'sh0000;
    badCount = 0;
    checkCount = 0;
    thr = '{`RDV_THR_15V, `RDV_THR_21V, `RDV_THR_45V, `RDV_THR_45V};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    check(16'(ringPin), 16'h0001);
    check(16'(irqOutPin), 16'h0001);
    check(pcmTxSamples, `RDV_CODE_LOW);
    wr(8'h01, 8'hFF);
    wr(8'h10, 8'hFF);
    rd(8'h01);
    check(16'(v), 16'h0081);
    rd(8'h10);
    check(16'(v), 16'h0000);
    fin("reset");
    // Each threshold select combination
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 8'(i % 2));
      wr(8'h01, 8'(8'h80 | (i / 2)));
      st(thr[i], 8'h00, `RDV_CODE_LOW, 1'b1);
      st(thr[i] + 1, 8'h01, `RDV_CODE_HIGH, 1'b0);
      st(-thr[i] - 1, 8'h02, `RDV_CODE_LOW, 1'b1);
      st(-thr[i], 8'h00, `RDV_CODE_LOW, 1'b1);
    end
    fin("threshold");
    wr(8'h00, 8'h02);
    wr(8'h01, 8'h80);
    st(0, 8'h00, `RDV_CODE_MID, 1'b1);
    st(1501, 8'h01, `RDV_CODE_HIGH, 1'b0);
    st(-1501, 8'h02, `RDV_CODE_LOW, 1'b0);
    wr(8'h00, 8'h0A);
    st(-1501, 8'h02, `RDV_CODE_LOW, 1'b1);
    st(0, 8'h00, `RDV_CODE_MID, 1'b0);
    wr(8'h00, 8'h00);
    sv(1501);
    for (int b = 5; b < 8; b++)
    begin
      wr(8'h00, 8'(1 << b));
      cyc(2);
      check(pcmTxSamples, prevCodec);
      wr(8'h00, 8'h00);
    end
    fin("pcm");
    sv(0);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    wr(8'h06, 8'h80);
    rd(8'h06);
    check(16'(v), 16'h0000);
    pulse(1501);
    cyc(4);
    rd(8'h06);
    check(16'(v), 16'h0084);
    check(16'(irqOutPin), 16'h0000);
    wr(8'h00, 8'h10);
    cyc(1);
    check(16'(irqOutPin), 16'h0001);
    wr(8'h00, 8'h00);
    wr(8'h06, 8'h80);
    rd(8'h06);
    check(16'(v), 16'h0004);
    cyc(140);
    rd(8'h06);
    check(16'(v), 16'h0004);
    cyc(60);
    rd(8'h06);
    check(16'(v), 16'h0000);
    // Retrigger with both-edge interrupts
    wr(8'h00, 8'h04);
    pulse(1501);
    cyc(4);
    wr(8'h06, 8'h80);
    cyc(140);
    pulse(1501);
    cyc(150);
    rd(8'h06);
    check(16'(v), 16'h0004);
    cyc(60);
    rd(8'h06);
    check(16'(v), 16'h0080);
    wr(8'h06, 8'h80);
    pulse(-1501);
    cyc(4);
    rd(8'h06);
    check(16'(v), 16'h0000);
    wr(8'h00, 8'h06);
    pulse(-1501);
    cyc(4);
    rd(8'h06);
    check(16'(v), 16'h0084);
    wr(8'h00, 8'h86);
    rd(8'h06);
    check(16'(v & 8'h07), 16'h0000);
    fin("oneshot");
    // Validator: slow 10, min 2, confirm 7, end 5, delay 7 ticks
    wr(8'h02, 8'h85);
    wr(8'h03, 8'h02);
    wr(8'h04, 8'h2F);
    wr(8'h05, 8'h07);
    wr(8'h00, 8'h02);
    wr(8'h06, 8'h80);
    pulse(1501);
    cyc(120);
    rd(8'h06);
    check(16'(v), 16'h0000);
    check(16'(ringPin), 16'h0000);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    ring(2, 20);
    sv(0);
    cyc(60);
    rd(8'h06);
    check(16'(v), 16'h0000);
    // Confirmed, then silent before the delay runs out
    ring(14, 1);
    sv(0);
    cyc(60);
    rd(8'h06);
    check(16'(v), 16'h0000);
    ring(14, 8);
    sv(1501);
    rd(8'h06);
    check(16'(v & 8'h84), 16'h0084);
    check(16'(ringPin), 16'h0000);
    sv(0);
    cyc(60);
    rd(8'h06);
    check(16'(v & 8'h04), 16'h0000);
    check(16'(ringPin), 16'h0001);
    wr(8'h02, 8'h0A);
    pulse(1501);
    cyc(4);
    rd(8'h06);
    check(16'(v & 8'h04), 16'h0004);
    fin("validate");
    conclude();
  end
endmodule
